// file: logic/alarm_digital_io_monitor.sv
// alarm monitor top: digital inputs, digital output, fault indicator, event sinks, ahb-lite registers
//
// Overview of operation
// RQ1: digital input detection and output driving run only while the io enable is set, else the output is inactive.
// RQ2: each digital input raises an event on its selected edge, falling or rising.
// RQ3: each event goes to local log, remote syslog, trap and mail sinks, each with its own enable.
// RQ4: after reset the trap and mail sink enables are cleared.
// RQ5: a monitored port or power failure drives the digital output to the chosen level.
// RQ6: output triggers are individually chosen among port fail, power fail, input zero and input one events.
// RQ7: a power mask picks the monitored power inputs; unmasked inputs never count as power failure.
// RQ8: a port mask picks the monitored ports; only link loss on a selected port is a port failure.
// RQ9: the fault indicator path works only while its own enable is set, apart from the io enable.
// RQ10: software selects which failure classes, port and power, drive the fault indicator.
// RQ11: with both power inputs monitored, failure of either lights the fault indicator.
// RQ12: link loss on a selected port lights the fault indicator, unselected ports do not.
// RQ13: inputs pass a two-stage synchroniser and edge events are one-cycle pulses from synced samples.
`timescale 1ns/10ps
`default_nettype none
`include "alarm_regs.svh"
module alarm_digital_io_monitor #(
	parameter int NPORT = 10,
	parameter int NPWR = 2
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,

	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,

	// external contacts
	input wire logic alarm_input_zero,
	input wire logic alarm_input_one,

	// monitored health
	input wire logic [NPORT-1:0] port_link_up,
	input wire logic [NPWR-1:0] power_good,

	// alarm outputs
	output logic alarm_output,
	output logic fault_indicator,

	// event sinks
	output logic sink_local_log,
	output logic sink_remote_log,
	output logic sink_trap,
	output logic sink_mail,
	output logic [3:0] sink_source,

	// interrupt
	output logic irq
);

	// configuration registers
	logic [31:0] ctrl;
	logic [3:0] sink_en;
	logic [NPWR-1:0] pwr_mask;
	logic [NPORT-1:0] port_mask;
	logic [3:0] irq_en;

	// bus data phase state
	logic dp_write;
	logic dp_read;
	logic [7:0] dp_addr;

	// monitor state
	logic port_fail;
	logic power_fail;
	logic port_fail_q;
	logic power_fail_q;
	logic lvl0;
	logic lvl1;
	logic in0_pulse;
	logic in1_pulse;

	alarm_event_if ev_bus ();

	// control fields
	wire io_en = ctrl[`CTRL_IO_EN];
	wire fault_en = ctrl[`CTRL_FAULT_EN];
	wire edge0_rise = ctrl[`CTRL_EDGE0];
	wire edge1_rise = ctrl[`CTRL_EDGE1];
	wire out_lvl = ctrl[`CTRL_OUT_LVL];
	wire [3:0] trig_sel = ctrl[`CTRL_TRIG_LSB +: 4];
	wire [1:0] class_sel = ctrl[`CTRL_CLASS_LSB +: 2];
	wire cls_port = class_sel[0];
	wire cls_pwr = class_sel[1];

	// address phase decode
	wire take = hsel & hready & htrans[1];
	wire take_read = take & ~hwrite;
	wire take_write = take & hwrite & (hsize == `HSIZE_WORD);

	// data phase write strobes
	wire wr_ctrl = dp_write & (dp_addr == `REG_CTRL);
	wire wr_sink = dp_write & (dp_addr == `REG_SINK);
	wire wr_pwr = dp_write & (dp_addr == `REG_PWR_MASK);
	wire wr_port = dp_write & (dp_addr == `REG_PORT_MASK);
	wire wr_clear = dp_write & (dp_addr == `REG_CLEAR);
	wire wr_ien = dp_write & (dp_addr == `REG_IRQ_EN);

	// failure detection
	wire next_port_fail = alarm_pkg::any_fail(32'(port_mask), 32'(~port_link_up)); // RQ8
	wire next_power_fail = alarm_pkg::any_fail(32'(pwr_mask), 32'(~power_good)); // RQ7

	// fault events are recorded only through the fault path
	wire port_evt = fault_en & cls_port & port_fail & ~port_fail_q;
	wire pwr_evt = fault_en & cls_pwr & power_fail & ~power_fail_q;
	wire [3:0] evt = {pwr_evt, port_evt, in1_pulse, in0_pulse};
	wire any_evt = |evt;

	// digital output trigger sources, input events held by their sticky status
	wire [3:0] trig_src;
	assign trig_src[`EVT_IN0] = ev_bus.status[`EVT_IN0];
	assign trig_src[`EVT_IN1] = ev_bus.status[`EVT_IN1];
	assign trig_src[`EVT_PORT] = port_fail;
	assign trig_src[`EVT_PWR] = power_fail;
	wire trig_hit = io_en & |(trig_sel & trig_src); // RQ6
	wire next_alarm_output = trig_hit ? out_lvl : ~out_lvl; // RQ1 RQ5

	// fault indicator
	wire next_fault = fault_en & ((cls_port & port_fail) | (cls_pwr & power_fail)); // RQ9 RQ10

	// status block hookup
	assign ev_bus.evt = evt;
	assign ev_bus.clr = wr_clear ? hwdata[3:0] : 4'h0;
	assign ev_bus.ien = irq_en;

	// read multiplexer
	wire [31:0] live = 32'({fault_indicator, alarm_output, power_fail, port_fail, lvl1, lvl0});
	wire [31:0] rd_word =
		(dp_addr == `REG_CTRL) ? ctrl :
		(dp_addr == `REG_SINK) ? 32'(sink_en) :
		(dp_addr == `REG_PWR_MASK) ? 32'(pwr_mask) :
		(dp_addr == `REG_PORT_MASK) ? 32'(port_mask) :
		(dp_addr == `REG_STATUS) ? 32'(ev_bus.status) :
		(dp_addr == `REG_IRQ_EN) ? 32'(irq_en) :
		(dp_addr == `REG_LIVE) ? live :
		32'h00000000;

	alarm_input_edge u_edge0 (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(alarm_input_zero),
		.rising(edge0_rise),
		.enable(io_en),
		.level(lvl0),
		.pulse(in0_pulse)
	);

	alarm_input_edge u_edge1 (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(alarm_input_one),
		.rising(edge1_rise),
		.enable(io_en),
		.level(lvl1),
		.pulse(in1_pulse)
	);

	alarm_event_status u_status (
		.hclk(hclk),
		.hresetn(hresetn),
		.ev(ev_bus)
	);

	// bus phase tracking; reads take one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_read <= 1'b0;
			dp_addr <= 8'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end else begin
			dp_write <= take_write;
			dp_read <= take_read;
			if (take) begin
				dp_addr <= haddr[7:0];
			end
			hreadyout <= ~take_read;
			if (dp_read) begin
				hrdata <= rd_word;
			end
			hresp <= 1'b0;
		end
	end

	// configuration writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `CTRL_RST;
			sink_en <= `SINK_RST; // RQ4
			pwr_mask <= '0;
			port_mask <= '0;
			irq_en <= `IRQ_EN_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl <= hwdata & `CTRL_WMASK;
			end
			if (wr_sink) begin
				sink_en <= hwdata[3:0];
			end
			if (wr_pwr) begin
				pwr_mask <= hwdata[NPWR-1:0];
			end
			if (wr_port) begin
				port_mask <= hwdata[NPORT-1:0];
			end
			if (wr_ien) begin
				irq_en <= hwdata[3:0];
			end
		end
	end

	// monitor, outputs and sinks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_fail <= 1'b0;
			power_fail <= 1'b0;
			port_fail_q <= 1'b0;
			power_fail_q <= 1'b0;
			alarm_output <= 1'b1;
			fault_indicator <= 1'b0;
			sink_local_log <= 1'b0;
			sink_remote_log <= 1'b0;
			sink_trap <= 1'b0;
			sink_mail <= 1'b0;
			sink_source <= 4'h0;
			irq <= 1'b0;
		end else begin
			port_fail <= next_port_fail; // RQ8
			power_fail <= next_power_fail; // RQ7
			port_fail_q <= port_fail;
			power_fail_q <= power_fail;
			alarm_output <= next_alarm_output; // RQ5
			fault_indicator <= next_fault; // RQ11 RQ12
			sink_local_log <= any_evt & sink_en[`SINK_LOCAL]; // RQ3
			sink_remote_log <= any_evt & sink_en[`SINK_REMOTE]; // RQ3
			sink_trap <= any_evt & sink_en[`SINK_TRAP]; // RQ3
			sink_mail <= any_evt & sink_en[`SINK_MAIL]; // RQ3
			sink_source <= evt;
			irq <= ev_bus.irq;
		end
	end

	property p_io_off;
		@(posedge hclk) disable iff (!hresetn)
		!io_en |=> !in0_pulse && !in1_pulse && alarm_output == !$past(out_lvl);
	endproperty
	a_io_off: assert property (p_io_off) else $error("io disabled but input or output active"); // RQ1

	property p_sink_route;
		@(posedge hclk) disable iff (!hresetn)
		any_evt |=> sink_local_log == $past(sink_en[0]) && sink_remote_log == $past(sink_en[1])
			&& sink_trap == $past(sink_en[2]) && sink_mail == $past(sink_en[3]) && sink_source == $past(evt);
	endproperty
	a_sink_route: assert property (p_sink_route) else $error("event routed to wrong sinks"); // RQ3

	property p_sink_reset;
		@(posedge hclk) disable iff (!hresetn)
		$past(!hresetn) |-> !sink_en[2] && !sink_en[3];
	endproperty
	a_sink_reset: assert property (p_sink_reset) else $error("trap or mail enabled out of reset"); // RQ4

	property p_out_port;
		@(posedge hclk) disable iff (!hresetn)
		io_en && trig_sel[2] && port_fail |=> alarm_output == $past(out_lvl);
	endproperty
	a_out_port: assert property (p_out_port) else $error("port failure did not drive output level"); // RQ5

	property p_out_source;
		@(posedge hclk) disable iff (!hresetn)
		io_en && (trig_sel & trig_src) == 4'h0 |=> alarm_output == !$past(out_lvl);
	endproperty
	a_out_source: assert property (p_out_source) else $error("output asserted without selected source"); // RQ6

	property p_pwr_mask;
		@(posedge hclk) disable iff (!hresetn)
		(32'(pwr_mask) & 32'(~power_good)) == 32'h00000000 |=> !power_fail;
	endproperty
	a_pwr_mask: assert property (p_pwr_mask) else $error("unmonitored power input counted"); // RQ7

	property p_port_mask;
		@(posedge hclk) disable iff (!hresetn)
		(32'(port_mask) & 32'(~port_link_up)) != 32'h00000000 |=> port_fail;
	endproperty
	a_port_mask: assert property (p_port_mask) else $error("selected port link loss missed"); // RQ8

	property p_fault_off;
		@(posedge hclk) disable iff (!hresetn)
		!fault_en |=> !fault_indicator;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault indicator lit while disabled"); // RQ9

	property p_fault_class;
		@(posedge hclk) disable iff (!hresetn)
		!cls_port && !cls_pwr |=> !fault_indicator;
	endproperty
	a_fault_class: assert property (p_fault_class) else $error("fault lit with no class selected"); // RQ10

	property p_fault_pwr;
		@(posedge hclk) disable iff (!hresetn)
		fault_en && cls_pwr && power_fail |=> fault_indicator;
	endproperty
	a_fault_pwr: assert property (p_fault_pwr) else $error("power failure did not light fault"); // RQ11

	property p_fault_port;
		@(posedge hclk) disable iff (!hresetn)
		fault_en && cls_port && port_fail |=> fault_indicator;
	endproperty
	a_fault_port: assert property (p_fault_port) else $error("port failure did not light fault"); // RQ12

	property p_input_path;
		@(posedge hclk) disable iff (!hresetn)
		$rose(alarm_input_zero) ##2 (io_en && edge0_rise) |=> in0_pulse;
	endproperty
	a_input_path: assert property (p_input_path) else $error("input edge not seen after two stages"); // RQ13

	property p_out_pwr;
		@(posedge hclk) disable iff (!hresetn)
		io_en && trig_sel[`EVT_PWR] && power_fail |=> alarm_output == $past(out_lvl);
	endproperty
	a_out_pwr: assert property (p_out_pwr) else $error("power failure did not drive output level"); // RQ6

	property p_out_input;
		@(posedge hclk) disable iff (!hresetn)
		io_en && trig_sel[`EVT_IN1] && ev_bus.status[`EVT_IN1] |=> alarm_output == $past(out_lvl);
	endproperty
	a_out_input: assert property (p_out_input) else $error("input event did not drive output level"); // RQ6

	property p_fault_record;
		@(posedge hclk) disable iff (!hresetn)
		fault_en && cls_pwr && power_fail && !power_fail_q |=> sink_source[`EVT_PWR] && ev_bus.status[`EVT_PWR];
	endproperty
	a_fault_record: assert property (p_fault_record) else $error("power failure event not recorded"); // RQ3
endmodule
`default_nettype wire

// file: inc/alarm_regs.svh
// register offsets, field positions and reset values of the alarm monitor
`ifndef ALARM_REGS_SVH
`define ALARM_REGS_SVH
`define REG_CTRL 8'h00
`define REG_SINK 8'h04
`define REG_PWR_MASK 8'h08
`define REG_PORT_MASK 8'h0C
`define REG_STATUS 8'h10
`define REG_CLEAR 8'h14
`define REG_IRQ_EN 8'h18
`define REG_LIVE 8'h1C
`define CTRL_IO_EN 0
`define CTRL_FAULT_EN 1
`define CTRL_EDGE0 2
`define CTRL_EDGE1 3
`define CTRL_OUT_LVL 4
`define CTRL_TRIG_LSB 8
`define CTRL_CLASS_LSB 12
`define CTRL_WMASK 32'h00003F1F
`define CTRL_RST 32'h00000000
`define SINK_RST 4'h3
`define IRQ_EN_RST 4'h0
`define EVT_IN0 0
`define EVT_IN1 1
`define EVT_PORT 2
`define EVT_PWR 3
`define SINK_LOCAL 0
`define SINK_REMOTE 1
`define SINK_TRAP 2
`define SINK_MAIL 3
`define HSIZE_WORD 3'h2
`endif

// file: inc/alarm_pkg.sv
// types and shared helpers of the alarm monitor
package alarm_pkg;
	typedef logic [3:0] evt_t;

	function automatic logic edge_hit(input logic rising, input logic cur, input logic prev);
		edge_hit = rising ? (cur & ~prev) : (~cur & prev);
	endfunction

	function automatic logic any_fail(input logic [31:0] mask, input logic [31:0] bad);
		any_fail = |(mask & bad);
	endfunction
endpackage

// file: inc/alarm_event_if.sv
// event, clear and status signals between the monitor and its status keeper
`timescale 1ns/10ps
`default_nettype none
interface alarm_event_if;
	alarm_pkg::evt_t evt;
	alarm_pkg::evt_t clr;
	alarm_pkg::evt_t ien;
	alarm_pkg::evt_t status;
	logic irq;
	modport producer (output evt, output clr, output ien, input status, input irq);
	modport keeper (input evt, input clr, input ien, output status, output irq);
endinterface
`default_nettype wire

// file: logic/alarm_input_edge.sv
// two-stage synchroniser and selectable edge detector for one alarm input
`timescale 1ns/10ps
`default_nettype none
module alarm_input_edge (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pin and control
	input wire logic pin,
	input wire logic rising,
	input wire logic enable,
	// results
	output logic level,
	output logic pulse
);
	logic sync1;
	logic prev;
	wire hit = alarm_pkg::edge_hit(rising, level, prev);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= 1'b0;
			level <= 1'b0;
			prev <= 1'b0;
			pulse <= 1'b0;
		end else begin
			sync1 <= pin; // RQ13
			level <= sync1; // RQ13
			prev <= level;
			pulse <= enable & hit; // RQ2
		end
	end

	property p_edge_pulse;
		@(posedge hclk) disable iff (!hresetn)
		enable && (rising ? (level && !prev) : (!level && prev)) |=> pulse;
	endproperty
	a_edge_pulse: assert property (p_edge_pulse) else $error("selected edge gave no pulse"); // RQ2

	property p_single_pulse;
		@(posedge hclk) disable iff (!hresetn)
		pulse |=> !pulse;
	endproperty
	a_single_pulse: assert property (p_single_pulse) else $error("edge pulse longer than one cycle"); // RQ13
endmodule
`default_nettype wire

// file: logic/alarm_event_status.sv
// sticky event status with clear and enable, one level interrupt
`timescale 1ns/10ps
`default_nettype none
module alarm_event_status (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// events in, status out
	alarm_event_if.keeper ev
);
	alarm_pkg::evt_t next_status;
	assign next_status = (ev.status & ~ev.clr) | ev.evt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev.status <= 4'h0;
			ev.irq <= 1'b0;
		end else begin
			ev.status <= next_status;
			ev.irq <= |(next_status & ev.ien);
		end
	end

	property p_set_wins;
		@(posedge hclk) disable iff (!hresetn)
		(ev.evt & ev.clr) != 4'h0 |=> (ev.status & $past(ev.evt & ev.clr)) == $past(ev.evt & ev.clr);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

	property p_irq_level;
		@(posedge hclk) disable iff (!hresetn)
		ev.irq == ((ev.status & $past(ev.ien)) != 4'h0);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt disagrees with status");
endmodule
`default_nettype wire

// file: testbench/alarm_contacts_model.sv
// behavioural model of the external contacts, port links and power feeds
`timescale 1ns/10ps
`default_nettype none
module alarm_contacts_model (
	// clock
	input wire logic hclk,
	// commanded levels
	input wire logic c_in0,
	input wire logic c_in1,
	input wire logic [9:0] c_link,
	input wire logic [1:0] c_pwr,
	// pins towards the monitor
	output logic pin0,
	output logic pin1,
	output logic [9:0] link,
	output logic [1:0] pwr
);
	// contacts change only on a clock edge and hold for many cycles
	always @(posedge hclk) begin
		pin0 <= c_in0;
		pin1 <= c_in1;
		link <= c_link;
		pwr <= c_pwr;
	end
endmodule
`default_nettype wire

// file: testbench/alarm_digital_io_monitor_tb.sv
// self-checking bench of the alarm monitor
`timescale 1ns/10ps
`default_nettype none
`include "alarm_regs.svh"
module alarm_digital_io_monitor_tb;
	logic hclk, hresetn, hsel, hwrite, c_in0, c_in1;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0] htrans, c_pwr;
	logic [2:0] hsize;
	logic [9:0] c_link;
	logic [3:0] src_or = 4'h0;
	wire logic hreadyout, hresp, alarm_output, fault_indicator, irq, pin0, pin1, s_loc, s_rem, s_trap, s_mail;
	wire logic [31:0] hrdata;
	wire logic [3:0] s_src;
	wire logic [9:0] link;
	wire logic [1:0] pwr;
	int bad_count = 0, cmp_count = 0, n_loc = 0, n_rem = 0, n_trap = 0, n_mail = 0;

	alarm_digital_io_monitor #(.NPORT(10), .NPWR(2)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .alarm_input_zero(pin0), .alarm_input_one(pin1),
		.port_link_up(link), .power_good(pwr), .alarm_output(alarm_output), .fault_indicator(fault_indicator),
		.sink_local_log(s_loc), .sink_remote_log(s_rem), .sink_trap(s_trap), .sink_mail(s_mail),
		.sink_source(s_src), .irq(irq));
	alarm_contacts_model partner (.hclk(hclk), .c_in0(c_in0), .c_in1(c_in1), .c_link(c_link), .c_pwr(c_pwr),
		.pin0(pin0), .pin1(pin1), .link(link), .pwr(pwr));

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// sink pulses counted in settled mid-cycle samples
	always @(negedge hclk) begin
		if (s_loc === 1'b1) n_loc++;
		if (s_rem === 1'b1) n_rem++;
		if (s_trap === 1'b1) n_trap++;
		if (s_mail === 1'b1) n_mail++;
		if ((s_loc | s_rem | s_trap | s_mail) === 1'b1) src_or |= s_src;
	end

	task automatic stop_test;
		if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			bad_count++;
			stop_test();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hwrite <= w;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		repeat (3) @(posedge hclk);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(nm, rd, exp);
	endtask

	task automatic pins(input logic d0, input logic d1, input logic [9:0] l, input logic [1:0] p);
		c_in0 <= d0;
		c_in1 <= d1;
		c_link <= l;
		c_pwr <= p;
		repeat (6) @(posedge hclk);
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		htrans = 2'h0;
		hsize = `HSIZE_WORD;
		c_in0 = 1'b0;
		c_in1 = 1'b0;
		c_link = 10'h3FF;
		c_pwr = 2'h3;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("alarm_output", alarm_output, 32'h1);
		rdc("ctrl", `REG_CTRL, 32'h0);
		chk("hresp", hresp, 32'h0);
		rdc("sink", `REG_SINK, 32'h3);
		rdc("pwr_mask", `REG_PWR_MASK, 32'h0);
		rdc("port_mask", `REG_PORT_MASK, 32'h0);
		rdc("irq_en", `REG_IRQ_EN, 32'h0);
		rdc("unmapped", 8'h20, 32'h0);
		hsize <= 3'h0;
		wr(`REG_PORT_MASK, 32'h000003FF);
		hsize <= `HSIZE_WORD;
		rdc("port_mask byte", `REG_PORT_MASK, 32'h0);
		wr(`REG_CTRL, 32'h00000004);
		pins(1'b1, 1'b0, 10'h3FF, 2'h3);
		rdc("status off", `REG_STATUS, 32'h0);
		chk("local off", n_loc, 32'h0);
		pins(1'b0, 1'b0, 10'h3FF, 2'h3);
		wr(`REG_CTRL, 32'h00000005);
		wr(`REG_IRQ_EN, 32'h00000001);
		pins(1'b1, 1'b0, 10'h3FF, 2'h3);
		rdc("status rise", `REG_STATUS, 32'h1);
		chk("local", n_loc, 32'h1);
		chk("remote", n_rem, 32'h1);
		chk("trap", n_trap, 32'h0);
		chk("mail", n_mail, 32'h0);
		chk("source", src_or, 32'h1);
		chk("irq", irq, 32'h1);
		pins(1'b1, 1'b1, 10'h3FF, 2'h3);
		rdc("status rise1", `REG_STATUS, 32'h1);
		wr(`REG_SINK, 32'h0000000C);
		pins(1'b1, 1'b0, 10'h3FF, 2'h3);
		rdc("status fall1", `REG_STATUS, 32'h3);
		chk("trap on", n_trap, 32'h1);
		chk("mail on", n_mail, 32'h1);
		chk("local off", n_loc, 32'h1);
		chk("source", src_or, 32'h3);
		wr(`REG_CLEAR, 32'h00000001);
		rdc("status clr", `REG_STATUS, 32'h2);
		chk("irq clr", irq, 32'h0);
		wr(`REG_CTRL, 32'h00000205);
		chk("out di1", alarm_output, 32'h0);
		wr(`REG_CLEAR, 32'h00000002);
		chk("out idle", alarm_output, 32'h1);
		wr(`REG_PORT_MASK, 32'h00000004);
		wr(`REG_CTRL, 32'h00000415);
		pins(1'b1, 1'b0, 10'h3F7, 2'h3);
		chk("out port unsel", alarm_output, 32'h0);
		pins(1'b1, 1'b0, 10'h3FB, 2'h3);
		chk("out port", alarm_output, 32'h1);
		wr(`REG_CTRL, 32'h00000414);
		chk("out io off", alarm_output, 32'h0);
		wr(`REG_PWR_MASK, 32'h00000001);
		wr(`REG_CTRL, 32'h00000815);
		pins(1'b1, 1'b0, 10'h3FB, 2'h3);
		chk("out port unsel trig", alarm_output, 32'h0);
		pins(1'b1, 1'b0, 10'h3FF, 2'h1);
		chk("out pwr unmasked", alarm_output, 32'h0);
		pins(1'b1, 1'b0, 10'h3FF, 2'h2);
		chk("out pwr", alarm_output, 32'h1);
		wr(`REG_PWR_MASK, 32'h00000003);
		wr(`REG_CTRL, 32'h00003000);
		pins(1'b1, 1'b0, 10'h3FB, 2'h3);
		chk("fault off", fault_indicator, 32'h0);
		wr(`REG_CTRL, 32'h00003002);
		chk("fault on", fault_indicator, 32'h1);
		wr(`REG_CTRL, 32'h00002002);
		chk("fault class", fault_indicator, 32'h0);
		pins(1'b1, 1'b0, 10'h3FF, 2'h2);
		chk("fault pwr0", fault_indicator, 32'h1);
		pins(1'b1, 1'b0, 10'h3FF, 2'h1);
		chk("fault pwr1", fault_indicator, 32'h1);
		wr(`REG_CTRL, 32'h00001002);
		pins(1'b1, 1'b0, 10'h3F7, 2'h3);
		chk("fault port unsel", fault_indicator, 32'h0);
		pins(1'b1, 1'b0, 10'h3FB, 2'h3);
		chk("fault port", fault_indicator, 32'h1);
		rdc("live", `REG_LIVE, 32'h00000035);
		stop_test();
	end
endmodule
`default_nettype wire
